// ---- src/pulse_timer_pkg.sv ----
// shared constants and types of the pulse timer unit
package pulse_timer_pkg;

	localparam int CNT_W     = 16;
	localparam int NUM_CH    = 6;
	localparam int NUM_SRC   = 26;
	localparam int NUM_MATCH = 16;
	localparam int ADDR_W    = 8;

	// request sources in reset priority order, channel by channel
	localparam int SRC_BASE   [NUM_CH] = '{0, 5, 9, 13, 18, 22};
	localparam int MATCH_BASE [NUM_CH] = '{0, 4, 6, 8, 12, 14};
	localparam int NUM_GR     [NUM_CH] = '{4, 2, 2, 4, 2, 2};

	// channels that may run in two-phase mode 4
	localparam logic [5:0] PHASE_CAPABLE = 6'h36;

	// register byte offsets
	localparam logic [7:0] OFS_RUN     = 8'h00;
	localparam logic [7:0] OFS_PHASE   = 8'h04;
	localparam logic [7:0] OFS_CAPSEL  = 8'h08;
	localparam logic [7:0] OFS_CLEAR   = 8'h0c;
	localparam logic [7:0] OFS_STATUS  = 8'h10;
	localparam logic [7:0] OFS_ENABLE  = 8'h14;
	localparam logic [7:0] OFS_DIR     = 8'h18;
	localparam logic [7:0] OFS_COUNTER = 8'h20;
	localparam logic [7:0] OFS_GENERAL = 8'h40;
	localparam logic [7:0] OFS_GEN_END = 8'ha0;

	// capture select field positions
	localparam int CAP_CH0B_CLK1 = 0;
	localparam int CAP_CH1A_M0A  = 1;
	localparam int CAP_CH1B_M0C  = 2;
	localparam int CAP_CH0_BUFBD = 3;
	// clear select: bits 5:0 clear on register A match, bit 6 clears channel 0 on C match
	localparam int CLR_CH0_C     = 6;

	// reset values
	localparam logic [31:0] RST_ZERO = 32'h0000_0000;

	typedef struct packed {
		logic             en;
		logic [2:0]       idx;
		logic [CNT_W-1:0] data;
	} cnt_write_t;

endpackage : pulse_timer_pkg

// ---- src/phase4_decoder.sv ----
// two-phase encoder decoder, counting mode 4
`timescale 1ns/1ns
module phase4_decoder
	import pulse_timer_pkg::*;
(
	input  wire logic clk_in,
	input  wire logic rst_n_in,
	input  wire logic phase_a_in,
	input  wire logic phase_b_in,
	output logic      up_out,
	output logic      down_out
);

	logic [1:0] a_sync;
	logic [1:0] b_sync;
	logic       b_last;

	// both phases sampled on the same edge through two flops
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			a_sync <= 2'h0;
			b_sync <= 2'h0;
			b_last <= 1'b0;
		end else begin
			a_sync <= {a_sync[0], phase_a_in};
			b_sync <= {b_sync[0], phase_b_in};
			b_last <= b_sync[1];
		end
	end

	wire b_rise = b_sync[1] & ~b_last;
	wire b_fall = ~b_sync[1] & b_last;

	// only b edges count, a level picks the direction
	assign up_out   = (b_rise & a_sync[1]) | (b_fall & ~a_sync[1]);
	assign down_out = (b_rise & ~a_sync[1]) | (b_fall & a_sync[1]);

endmodule : phase4_decoder

// ---- src/channel_counter.sv ----
// one timer channel: counter, general registers, match and wrap events
`timescale 1ns/1ns
module channel_counter
	import pulse_timer_pkg::*;
#(
	parameter int NGR = 4
) (
	input  wire logic             clk_in,
	input  wire logic             rst_n_in,
	input  wire logic             inc_in,
	input  wire logic             dec_in,
	input  wire logic [3:0]       cap_mode_in,
	input  wire logic [3:0]       cap_strobe_in,
	input  wire logic             buffer_bd_in,
	input  wire logic [3:0]       clear_mask_in,
	input  wire cnt_write_t       wr_in,
	output logic      [CNT_W-1:0] count_out,
	output logic      [CNT_W-1:0] gr_out [4],
	output logic      [3:0]       match_out,
	output logic                  ovf_out,
	output logic                  unf_out,
	output logic                  dir_out
);

	logic [CNT_W-1:0] up_down_counter;
	logic [CNT_W-1:0] general_register [4];
	logic             dir;

	wire step = inc_in | dec_in;

	genvar i;
	for (i = 0; i < 4; i++) begin : g_gr
		if (i < NGR) begin : g_on
			// capture source or compare match on counter step
			assign match_out[i] = cap_mode_in[i] ? cap_strobe_in[i] :
				(step & (up_down_counter == general_register[i]));
			always_ff @(posedge clk_in) begin
				if (!rst_n_in) begin
					general_register[i] <= RST_ZERO[CNT_W-1:0];
				end else if (cap_mode_in[i] & cap_strobe_in[i]) begin
					general_register[i] <= up_down_counter;
				end else if (i == 3 && buffer_bd_in && cap_mode_in[1] && cap_strobe_in[1]) begin
					general_register[i] <= general_register[1];
				end else if (wr_in.en && wr_in.idx == 3'(i + 1)) begin
					general_register[i] <= wr_in.data;
				end
			end
		end else begin : g_off
			assign match_out[i] = 1'b0;
			always_ff @(posedge clk_in) begin
				general_register[i] <= RST_ZERO[CNT_W-1:0];
			end
		end
		assign gr_out[i] = general_register[i];
	end

	wire clear = |(match_out & clear_mask_in);

	// wrap events follow the count direction
	assign ovf_out = inc_in & (up_down_counter == {CNT_W{1'b1}});
	assign unf_out = dec_in & (up_down_counter == RST_ZERO[CNT_W-1:0]);

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			up_down_counter <= RST_ZERO[CNT_W-1:0];
			dir             <= 1'b0;
		end else begin
			if (clear) begin
				up_down_counter <= RST_ZERO[CNT_W-1:0];
			end else if (wr_in.en && wr_in.idx == 3'h0) begin
				up_down_counter <= wr_in.data;
			end else if (inc_in) begin
				up_down_counter <= up_down_counter + 1'b1;
			end else if (dec_in) begin
				up_down_counter <= up_down_counter - 1'b1;
			end
			if (inc_in) begin
				dir <= 1'b1;
			end else if (dec_in) begin
				dir <= 1'b0;
			end
		end
	end

	assign count_out = up_down_counter;
	assign dir_out   = dir;

endmodule : channel_counter

// ---- src/pulse_timer_unit.sv ----
// pulse timer unit: six channels, request flags, phase mode 4, avalon slave
//
// How it works
// - mode 4 counts on b edges only; a level sets up or down.
// - channels 1 and 5 use pins a/b, channels 2 and 4 use c/d.
// - match, overflow and underflow sources each own a flag and enable.
// - an event sets its flag; request rises only while enable is set.
// - request holds until its flag or its enable is cleared; either withdraws it.
// - within a channel priority is fixed; the controller orders channels.
// - sixteen match sources: four on channels 0 and 3, two elsewhere.
// - every channel has an overflow flag and request.
// - underflow flags and requests exist on channels 1, 2, 4, 5 only.
// - only match requests reach the transfer controller.
// - only register a match requests reach the dma controller.
// - sources are ordered channel by channel, matches, overflow, underflow.
// - channel 0 b captures on channel 1 count clock, buffered into d.
// - channel 1 a and b capture on channel 0 a and c matches.
// - overflow counting up, underflow counting down; direction flag readable.
// - phase mode forces encoder counting; clear and enables still work.
// - a started transfer clears its flag without software.
`timescale 1ns/1ns
module pulse_timer_unit
	import pulse_timer_pkg::*;
(
	input  wire logic                 clk_in,
	input  wire logic                 rst_n_in,
	input  wire logic [ADDR_W-1:0]    address_in,
	input  wire logic                 read_in,
	input  wire logic                 write_in,
	input  wire logic [31:0]          writedata_in,
	output logic      [31:0]          readdata_out,
	output logic                      waitrequest_out,
	input  wire logic                 ext_clk_in_a,
	input  wire logic                 ext_clk_in_b,
	input  wire logic                 ext_clk_in_c,
	input  wire logic                 ext_clk_in_d,
	input  wire logic [NUM_MATCH-1:0] xfer_ack_in,
	input  wire logic [NUM_CH-1:0]    dma_ack_in,
	output logic      [NUM_SRC-1:0]   irq_out,
	output logic      [NUM_MATCH-1:0] xfer_req_out,
	output logic      [NUM_CH-1:0]    dma_req_out
);

	logic [5:0]         run;
	logic [5:0]         phase_mode;
	logic [3:0]         capsel;
	logic [6:0]         clear_sel;
	logic [NUM_SRC-1:0] status_flags;
	logic [NUM_SRC-1:0] irq_enable;
	logic               wait_q;
	logic [31:0]        rdata;

	logic [CNT_W-1:0]   count_val [NUM_CH];
	logic [CNT_W-1:0]   gr_val    [NUM_CH][4];
	logic [3:0]         match     [NUM_CH];
	logic [NUM_CH-1:0]  ovf;
	logic [NUM_CH-1:0]  unf;
	logic [NUM_CH-1:0]  count_direction_flag;
	logic [NUM_CH-1:0]  inc;
	logic [NUM_CH-1:0]  dec;
	logic [NUM_SRC-1:0] src_event;
	logic [NUM_SRC-1:0] hw_clear;
	logic [NUM_SRC-1:0] src_dma_mask;
	logic [NUM_SRC-1:0] src_is_match;

	// avalon handshake: wait one cycle, then take at the edge with wait low
	wire req      = read_in | write_in;
	wire take     = req & ~wait_q;
	wire wr       = write_in & take;
	wire hit_run  = address_in == OFS_RUN;
	wire hit_ph   = address_in == OFS_PHASE;
	wire hit_cap  = address_in == OFS_CAPSEL;
	wire hit_clr  = address_in == OFS_CLEAR;
	wire hit_stat = address_in == OFS_STATUS;
	wire hit_en   = address_in == OFS_ENABLE;
	wire hit_dir  = address_in == OFS_DIR;

	wire [7:0] cnt_ofs = address_in - OFS_COUNTER;
	wire [7:0] gr_ofs  = address_in - OFS_GENERAL;
	wire       hit_cnt = address_in >= OFS_COUNTER && address_in < OFS_GENERAL
		&& cnt_ofs[1:0] == 2'h0 && cnt_ofs[4:2] < 3'(NUM_CH);
	wire       hit_gr  = address_in >= OFS_GENERAL && address_in < OFS_GEN_END
		&& gr_ofs[1:0] == 2'h0;
	wire [2:0] cnt_ch  = cnt_ofs[4:2];
	wire [2:0] gr_ch   = gr_ofs[6:4];
	wire [1:0] gr_idx  = gr_ofs[3:2];

	// software writes 0 to clear a flag, 1 leaves it
	wire [NUM_SRC-1:0] sw_clear    = (wr & hit_stat) ? ~writedata_in[NUM_SRC-1:0] : '0;
	// a new event wins over any clear in the same cycle
	wire [NUM_SRC-1:0] next_flags  = (status_flags & ~sw_clear & ~hw_clear) | src_event;
	// request follows the enable written in the same cycle, so it stays flag and enable
	wire [NUM_SRC-1:0] next_enable = (wr & hit_en) ? writedata_in[NUM_SRC-1:0] : irq_enable;
	wire [NUM_SRC-1:0] next_irq    = next_flags & next_enable;

	// encoder decoders shared by channel pairs
	logic up_ab;
	logic down_ab;
	logic up_cd;
	logic down_cd;

	phase4_decoder u_dec_ab (
		.clk_in     (clk_in),
		.rst_n_in   (rst_n_in),
		.phase_a_in (ext_clk_in_a),
		.phase_b_in (ext_clk_in_b),
		.up_out     (up_ab),
		.down_out   (down_ab)
	);

	phase4_decoder u_dec_cd (
		.clk_in     (clk_in),
		.rst_n_in   (rst_n_in),
		.phase_a_in (ext_clk_in_c),
		.phase_b_in (ext_clk_in_d),
		.up_out     (up_cd),
		.down_out   (down_cd)
	);

	genvar c;
	genvar k;
	for (c = 0; c < NUM_CH; c++) begin : g_ch
		localparam int NG   = NUM_GR[c];
		localparam int BASE = SRC_BASE[c];
		localparam int MB   = MATCH_BASE[c];
		localparam bit USE_AB = (c == 1) || (c == 5);

		wire phase_on = phase_mode[c] & PHASE_CAPABLE[c];
		wire enc_up   = USE_AB ? up_ab : up_cd;
		wire enc_down = USE_AB ? down_ab : down_cd;

		// phase mode overrides the internal clock
		assign inc[c] = run[c] & (phase_on ? enc_up : 1'b1);
		assign dec[c] = run[c] & phase_on & enc_down;

		wire [3:0] cap_mode;
		wire [3:0] cap_strobe;
		if (c == 0) begin : g_cap0
			assign cap_mode   = {2'b00, capsel[CAP_CH0B_CLK1], 1'b0};
			assign cap_strobe = {2'b00, inc[1] | dec[1], 1'b0};
		end else if (c == 1) begin : g_cap1
			assign cap_mode   = {2'b00, capsel[CAP_CH1B_M0C], capsel[CAP_CH1A_M0A]};
			assign cap_strobe = {2'b00, match[0][2], match[0][0]};
		end else begin : g_capn
			assign cap_mode   = 4'h0;
			assign cap_strobe = 4'h0;
		end

		wire [3:0] clr_mask = {1'b0, (c == 0) ? clear_sel[CLR_CH0_C] : 1'b0, 1'b0, clear_sel[c]};

		cnt_write_t wcmd;
		assign wcmd.en   = wr & ((hit_cnt & cnt_ch == 3'(c)) |
			(hit_gr & gr_ch == 3'(c) & 32'(gr_idx) < NG));
		assign wcmd.idx  = hit_cnt ? 3'h0 : {1'b0, gr_idx} + 3'h1;
		assign wcmd.data = writedata_in[CNT_W-1:0];

		channel_counter #(.NGR(NG)) u_ch (
			.clk_in        (clk_in),
			.rst_n_in      (rst_n_in),
			.inc_in        (inc[c]),
			.dec_in        (dec[c]),
			.cap_mode_in   (cap_mode),
			.cap_strobe_in (cap_strobe),
			.buffer_bd_in  ((c == 0) ? capsel[CAP_CH0_BUFBD] : 1'b0),
			.clear_mask_in (clr_mask),
			.wr_in         (wcmd),
			.count_out     (count_val[c]),
			.gr_out        (gr_val[c]),
			.match_out     (match[c]),
			.ovf_out       (ovf[c]),
			.unf_out       (unf[c]),
			.dir_out       (count_direction_flag[c])
		);

		// match sources in register order, then overflow, then underflow
		for (k = 0; k < NG; k++) begin : g_m
			assign src_event[BASE+k]    = match[c][k];
			// transfer start clears the flag
			assign hw_clear[BASE+k]     = xfer_ack_in[MB+k] | ((k == 0) & dma_ack_in[c]);
			assign src_is_match[BASE+k] = 1'b1;
			assign src_dma_mask[BASE+k] = (k == 0);
		end
		assign src_event[BASE+NG]    = ovf[c];
		assign hw_clear[BASE+NG]     = 1'b0;
		assign src_is_match[BASE+NG] = 1'b0;
		assign src_dma_mask[BASE+NG] = 1'b0;
		if (NG == 2) begin : g_unf
			assign src_event[BASE+NG+1]    = unf[c];
			assign hw_clear[BASE+NG+1]     = 1'b0;
			assign src_is_match[BASE+NG+1] = 1'b0;
			assign src_dma_mask[BASE+NG+1] = 1'b0;
		end

		for (k = 0; k < NG; k++) begin : g_xr
			always_ff @(posedge clk_in) begin
				if (!rst_n_in) begin
					xfer_req_out[MB+k] <= 1'b0;
				end else begin
					xfer_req_out[MB+k] <= next_irq[BASE+k] & src_is_match[BASE+k];
				end
			end
		end

		always_ff @(posedge clk_in) begin
			if (!rst_n_in) begin
				dma_req_out[c] <= 1'b0;
			end else begin
				dma_req_out[c] <= next_irq[BASE] & src_dma_mask[BASE];
			end
		end
	end

	// read mux
	wire [CNT_W-1:0] cnt_rd = (cnt_ch < 3'(NUM_CH)) ? count_val[cnt_ch] : '0;
	wire             gr_ok  = gr_ch < 3'(NUM_CH) && 32'(gr_idx) < NUM_GR[gr_ch];
	wire [CNT_W-1:0] gr_rd  = gr_ok ? gr_val[gr_ch][gr_idx] : '0;
	assign rdata = hit_run  ? {26'h0, run} :
		hit_ph   ? {26'h0, phase_mode} :
		hit_cap  ? {28'h0, capsel} :
		hit_clr  ? {25'h0, clear_sel} :
		hit_stat ? {6'h0, status_flags} :
		hit_en   ? {6'h0, irq_enable} :
		hit_dir  ? {26'h0, count_direction_flag} :
		hit_cnt  ? {16'h0, cnt_rd} :
		(hit_gr && gr_ok) ? {16'h0, gr_rd} : RST_ZERO;

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			wait_q       <= 1'b1;
			readdata_out <= RST_ZERO;
		end else begin
			wait_q       <= ~(req & wait_q);
			readdata_out <= (read_in & wait_q) ? rdata : readdata_out;
		end
	end
	assign waitrequest_out = wait_q;

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			run          <= RST_ZERO[5:0];
			phase_mode   <= RST_ZERO[5:0];
			capsel       <= RST_ZERO[3:0];
			clear_sel    <= RST_ZERO[6:0];
			irq_enable   <= RST_ZERO[NUM_SRC-1:0];
			status_flags <= RST_ZERO[NUM_SRC-1:0];
			irq_out      <= RST_ZERO[NUM_SRC-1:0];
		end else begin
			if (wr & hit_run) run <= writedata_in[5:0];
			if (wr & hit_ph) phase_mode <= writedata_in[5:0] & PHASE_CAPABLE;
			if (wr & hit_cap) capsel <= writedata_in[3:0];
			if (wr & hit_clr) clear_sel <= writedata_in[6:0];
			irq_enable   <= next_enable;
			status_flags <= next_flags;
			irq_out      <= next_irq;
		end
	end

endmodule : pulse_timer_unit

// ---- src/README_unused.sv ----
// intentionally empty
`timescale 1ns/1ns

// ---- tb/xfer_partner.sv ----
// transfer and dma controller model that answers match requests
`timescale 1ns/1ns
module xfer_partner
	import pulse_timer_pkg::*;
(
	input  wire logic                 clk_in,
	input  wire logic                 rst_n_in,
	input  wire logic                 on_in,
	input  wire logic [3:0]           delay_in,
	input  wire logic [NUM_MATCH-1:0] xfer_req_in,
	input  wire logic [NUM_CH-1:0]    dma_req_in,
	output logic      [NUM_MATCH-1:0] xfer_ack_out,
	output logic      [NUM_CH-1:0]    dma_ack_out
);
	logic [3:0] wait_cnt;
	// no new start while the last one is still clearing its flag
	wire logic busy = |xfer_ack_out || |dma_ack_out;
	wire logic pend = on_in && (|xfer_req_in || |dma_req_in) && !busy;
	wire logic fire = pend && wait_cnt >= delay_in;
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			wait_cnt     <= 4'h0;
			xfer_ack_out <= '0;
			dma_ack_out  <= '0;
		end else begin
			wait_cnt     <= (fire || !pend) ? 4'h0 : wait_cnt + 4'h1;
			xfer_ack_out <= fire ? xfer_req_in : '0;
			dma_ack_out  <= fire ? dma_req_in : '0;
		end
	end
endmodule : xfer_partner

// ---- tb/pulse_timer_props.sv ----
// port-level assertions for the pulse timer unit
`timescale 1ns/1ns
module pulse_timer_props
	import pulse_timer_pkg::*;
(
	input wire logic                 clk_in,
	input wire logic                 rst_n_in,
	input wire logic [ADDR_W-1:0]    address_in,
	input wire logic                 read_in,
	input wire logic                 write_in,
	input wire logic [31:0]          readdata_out,
	input wire logic                 waitrequest_out,
	input wire logic [NUM_MATCH-1:0] xfer_ack_in,
	input wire logic [NUM_CH-1:0]    dma_ack_in,
	input wire logic [NUM_SRC-1:0]   irq_out,
	input wire logic [NUM_MATCH-1:0] xfer_req_out,
	input wire logic [NUM_CH-1:0]    dma_req_out
);
	default clocking dc @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	wire logic sw_clr = write_in && !waitrequest_out &&
		(address_in == OFS_STATUS || address_in == OFS_ENABLE);
	wire logic any_ack = |xfer_ack_in || |dma_ack_in;
	sequence bus_req;
		(read_in || write_in) && waitrequest_out;
	endsequence
	sequence bus_ans;
		!waitrequest_out ##1 waitrequest_out;
	endsequence
	a_req_reset: assert property (disable iff (1'b0) !rst_n_in |=>
		!(|irq_out) && !(|xfer_req_out) && !(|dma_req_out))
		else $error("requests not idle after reset");
	a_wait_once: assert property (bus_req |=> bus_ans)
		else $error("waitrequest answer not one cycle");
	a_wait_cause: assert property (!waitrequest_out |-> $past(read_in || write_in))
		else $error("waitrequest low without request");
	a_unmapped_rd: assert property (read_in && !waitrequest_out &&
		(address_in == 8'h1c || address_in >= OFS_GEN_END) |-> readdata_out == RST_ZERO)
		else $error("unmapped read not zero");
	for (genvar j = 0; j < NUM_SRC; j++) begin : g_src
		a_irq_hold: assert property ($fell(irq_out[j]) |-> $past(sw_clr || any_ack))
			else $error("request dropped without clear");
	end
	for (genvar j = 0; j < NUM_MATCH; j++) begin : g_match
		a_xfer_hold: assert property ($fell(xfer_req_out[j]) |-> $past(sw_clr || any_ack))
			else $error("transfer request dropped without clear");
	end
	for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
		a_irq_dma: assert property (irq_out[SRC_BASE[c]] |-> dma_req_out[c])
			else $error("register a request without dma request");
		a_dma_only_a: assert property (dma_req_out[c] |-> irq_out[SRC_BASE[c]])
			else $error("dma request without register a request");
		for (genvar k = 0; k < NUM_GR[c]; k++) begin : g_gr
			a_irq_xfer: assert property (irq_out[SRC_BASE[c] + k] |->
				xfer_req_out[MATCH_BASE[c] + k])
				else $error("match request without transfer request");
		end
	end
endmodule : pulse_timer_props

bind pulse_timer_unit pulse_timer_props props_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
	.address_in(address_in), .read_in(read_in), .write_in(write_in),
	.readdata_out(readdata_out), .waitrequest_out(waitrequest_out),
	.xfer_ack_in(xfer_ack_in), .dma_ack_in(dma_ack_in), .irq_out(irq_out),
	.xfer_req_out(xfer_req_out), .dma_req_out(dma_req_out));

// ---- tb/test_pulse_timer_unit.sv ----
// self-checking bench for the pulse timer unit
`timescale 1ns/1ns
module test_pulse_timer_unit
	import pulse_timer_pkg::*;
;
	logic                 clk_in = 1'b0, rst_n_in = 1'b0, read_in = 1'b0, write_in = 1'b0;
	logic [7:0]           address_in = 8'h00;
	logic [31:0]          writedata_in = RST_ZERO, readdata_out, rdat;
	logic                 waitrequest_out, pon = 1'b0;
	logic                 ext_clk_in_a = 1'b0, ext_clk_in_b = 1'b0;
	logic                 ext_clk_in_c = 1'b0, ext_clk_in_d = 1'b0;
	logic [3:0]           dly = 4'h0;
	logic [NUM_MATCH-1:0] xfer_ack, xfer_req_out;
	logic [NUM_CH-1:0]    dma_ack, dma_req_out;
	logic [NUM_SRC-1:0]   irq_out;
	int                   n_fail = 0, checked = 0, cyc = 0;
	always #20 clk_in = !clk_in;
	pulse_timer_unit uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .address_in(address_in),
		.read_in(read_in), .write_in(write_in), .writedata_in(writedata_in),
		.readdata_out(readdata_out), .waitrequest_out(waitrequest_out),
		.ext_clk_in_a(ext_clk_in_a), .ext_clk_in_b(ext_clk_in_b), .ext_clk_in_c(ext_clk_in_c),
		.ext_clk_in_d(ext_clk_in_d), .xfer_ack_in(xfer_ack), .dma_ack_in(dma_ack),
		.irq_out(irq_out), .xfer_req_out(xfer_req_out), .dma_req_out(dma_req_out));
	xfer_partner partner (.clk_in(clk_in), .rst_n_in(rst_n_in), .on_in(pon), .delay_in(dly),
		.xfer_req_in(xfer_req_out), .dma_req_in(dma_req_out), .xfer_ack_out(xfer_ack),
		.dma_ack_out(dma_ack));
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : end_sim
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		address_in   <= a;
		writedata_in <= d;
		write_in     <= w;
		read_in      <= !w;
		do @(posedge clk_in); while (waitrequest_out !== 1'b0);
		rdat = readdata_out;
		write_in <= 1'b0;
		read_in  <= 1'b0;
	endtask : bus
	function automatic logic [7:0] gaddr(int ch, int k);
		return OFS_GENERAL + 8'(16 * ch + 4 * k);
	endfunction : gaddr
	function automatic logic [7:0] caddr(int ch);
		return OFS_COUNTER + 8'(4 * ch);
	endfunction : caddr
	// wrap flags {underflow, overflow} for a step that left value n
	function automatic logic [1:0] wrap(logic up, logic [15:0] n);
		return {!up && n == 16'hFFFF, up && n == 16'h0000};
	endfunction : wrap
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 8000) begin
			n_fail++;
			end_sim();
		end
	end
	initial begin
		logic [7:0]  ofs [6] = '{OFS_RUN, OFS_STATUS, OFS_ENABLE, OFS_DIR, 8'h1c, 8'ha0};
		logic [15:0] r;
		logic [15:0] ecnt [2] = '{16'h0000, 16'h0000};
		logic [1:0]  eflg [2] = '{2'b00, 2'b00};
		logic [1:0]  pa = 2'b00, pb = 2'b00, edir = 2'b11;
		logic        au, up;
		int          src;
		void'($urandom(1698));
		repeat (6) @(posedge clk_in);
		rst_n_in <= 1'b1;
		foreach (ofs[i]) begin
			bus(1'b1, ofs[i], i > 3 ? 32'hFFFF_FFFF : RST_ZERO);
			bus(1'b0, ofs[i], RST_ZERO);
			chk("reset or unmapped", rdat, RST_ZERO);
		end
		bus(1'b1, OFS_ENABLE, 32'h03FF_FFFF);
		for (int ch = 0; ch < NUM_CH; ch++) begin
			for (int k = 0; k < NUM_GR[ch]; k++) begin
				r = 16'h1000 * 16'(k + 1) + 16'($urandom_range(255));
				au = 1'($urandom_range(1));
				src = SRC_BASE[ch] + k;
				pon <= au;
				dly <= 4'($urandom_range(7));
				bus(1'b1, gaddr(ch, k), 32'(r));
				bus(1'b1, caddr(ch), 32'(r));
				bus(1'b1, OFS_RUN, 32'(1) << ch);
				bus(1'b1, OFS_RUN, RST_ZERO);
				repeat (12) @(posedge clk_in);
				bus(1'b0, OFS_STATUS, RST_ZERO);
				if (au) begin
					chk("auto clear", rdat, RST_ZERO);
				end else begin
					chk("flag", rdat, 32'(1) << src);
					chk("irq", 32'(irq_out), 32'(1) << src);
					chk("xfer", 32'(xfer_req_out), 32'(1) << (MATCH_BASE[ch] + k));
					chk("dma", 32'(dma_req_out), k == 0 ? 32'(1) << ch : RST_ZERO);
					bus(1'b1, OFS_ENABLE, RST_ZERO);
					@(negedge clk_in);
					chk("masked", 32'(irq_out), RST_ZERO);
					bus(1'b1, OFS_ENABLE, 32'h03FF_FFFF);
					bus(1'b1, OFS_STATUS, ~(32'(1) << src));
					@(negedge clk_in);
					chk("cleared", 32'(irq_out) | 32'(xfer_req_out), RST_ZERO);
				end
			end
		end
		pon <= 1'b0;
		for (int ch = 0; ch < NUM_CH; ch++) begin
			bus(1'b1, caddr(ch), 32'h0000_FFFE);
			bus(1'b1, OFS_RUN, 32'(1) << ch);
			bus(1'b1, OFS_RUN, RST_ZERO);
			@(negedge clk_in);
			chk("ovf irq", 32'(irq_out), 32'(1) << (SRC_BASE[ch] + NUM_GR[ch]));
			chk("ovf xfer", 32'(xfer_req_out) | 32'(dma_req_out), RST_ZERO);
			bus(1'b1, OFS_STATUS, RST_ZERO);
		end
		bus(1'b1, OFS_PHASE, 32'h0000_003F);
		bus(1'b0, OFS_PHASE, RST_ZERO);
		chk("phase", rdat, 32'(PHASE_CAPABLE));
		bus(1'b1, OFS_PHASE, 32'h0000_0006);
		bus(1'b1, caddr(1), RST_ZERO);
		bus(1'b1, caddr(2), RST_ZERO);
		bus(1'b1, OFS_RUN, 32'h0000_0006);
		for (int i = 0; i < 40; i++) begin
			for (int c = 0; c < 2; c++) begin
				if ($urandom_range(2) == 0) begin
					pa[c] = !pa[c];
				end else begin
					pb[c] = !pb[c];
					up = (pb[c] == pa[c]);
					ecnt[c] = up ? ecnt[c] + 16'h0001 : ecnt[c] - 16'h0001;
					eflg[c] = eflg[c] | wrap(up, ecnt[c]);
					edir[c] = up;
				end
			end
			ext_clk_in_a <= pa[0];
			ext_clk_in_b <= pb[0];
			ext_clk_in_c <= pa[1];
			ext_clk_in_d <= pb[1];
			repeat (5) @(posedge clk_in);
		end
		bus(1'b1, OFS_RUN, RST_ZERO);
		for (int c = 0; c < 2; c++) begin
			bus(1'b0, caddr(c + 1), RST_ZERO);
			chk("count", rdat, 32'(ecnt[c]));
		end
		bus(1'b1, OFS_DIR, RST_ZERO);
		bus(1'b0, OFS_DIR, RST_ZERO);
		chk("dir", rdat, {26'h0, 3'h7, edir, 1'b1});
		bus(1'b0, OFS_STATUS, RST_ZERO);
		chk("wrap flags", rdat, 32'({eflg[1], 2'b00, eflg[0]}) << 7);
		chk("wrap irq", 32'(irq_out), 32'({eflg[1], 2'b00, eflg[0]}) << 7);
		// channel 0 a and c matches capture channel 1, c match clears channel 0
		bus(1'b1, OFS_PHASE, RST_ZERO);
		bus(1'b1, OFS_STATUS, RST_ZERO);
		r = 16'h8000 | 16'($urandom_range(4095));
		ecnt = '{16'($urandom), 16'h6000 | 16'($urandom_range(4095))};
		bus(1'b1, gaddr(0, 0), 32'(r));
		bus(1'b1, gaddr(0, 2), 32'(r + 16'h0001));
		bus(1'b1, caddr(0), 32'(r));
		bus(1'b1, caddr(1), 32'(ecnt[0]));
		bus(1'b1, OFS_CAPSEL, 32'h0000_0006);
		bus(1'b1, OFS_CLEAR, 32'h0000_0040);
		bus(1'b1, OFS_RUN, 32'h0000_0001);
		bus(1'b1, OFS_RUN, RST_ZERO);
		bus(1'b0, OFS_STATUS, RST_ZERO);
		chk("capture flags", rdat, 32'h0000_0065);
		for (int k = 0; k < 2; k++) begin
			bus(1'b0, gaddr(1, k), RST_ZERO);
			chk("channel 1 capture", rdat, 32'(ecnt[0]));
		end
		bus(1'b0, caddr(0), RST_ZERO);
		chk("clear on c match", rdat, 32'h0000_0001);
		// channel 1 count clock captures channel 0 b, old b moves into d
		bus(1'b1, OFS_CLEAR, RST_ZERO);
		bus(1'b1, OFS_CAPSEL, 32'h0000_0009);
		bus(1'b1, caddr(0), 32'(ecnt[1]));
		bus(1'b1, OFS_RUN, 32'h0000_0003);
		bus(1'b1, OFS_RUN, RST_ZERO);
		bus(1'b0, gaddr(0, 1), RST_ZERO);
		chk("capture b", rdat, 32'(ecnt[1] + 16'h0002));
		bus(1'b0, gaddr(0, 3), RST_ZERO);
		chk("buffer d", rdat, 32'(ecnt[1] + 16'h0001));
		end_sim();
	end
endmodule : test_pulse_timer_unit
